/* File: hdl/iwd_defs.svh */
// Instruction word decoder constants: opcodes, field positions, cycle counts.
// Assumes inclusion by bare name from the field extract, cycle count and decoder top source files.
`ifndef IWD_DEFS_SVH
`define IWD_DEFS_SVH

// Field positions; bit 0 of the word is index 17 of the vector
`define IWD_OP_HI 17
`define IWD_OP_LO 14
`define IWD_IND_BIT 13
`define IWD_IDX_BIT 12
`define IWD_SUB_HI 13
`define IWD_SUB_LO 12
`define IWD_PAGE_ADDR_HI 11
`define IWD_BANK_ADDR_HI 12
`define IWD_MICRO_HI 13

// Operation codes in bits 0-3
`define IWD_OP_CALL 4'h0
`define IWD_OP_STORE 4'h1
`define IWD_OP_JSUB 4'h2
`define IWD_OP_ZERO 4'h3
`define IWD_OP_LOAD 4'h4
`define IWD_OP_XOR 4'h5
`define IWD_OP_ADD1 4'h6
`define IWD_OP_ADD2 4'h7
`define IWD_OP_EXEC 4'h8
`define IWD_OP_INCSKIP 4'h9
`define IWD_OP_AND 4'hA
`define IWD_OP_SKIPNE 4'hB
`define IWD_OP_JUMP 4'hC
`define IWD_OP_EAU 4'hD
`define IWD_OP_GRP7 4'hE
`define IWD_OP_OPR 4'hF
// Bits 4-5 inside the 1110 group
`define IWD_SUB_IOT 2'h0
`define IWD_SUB_INDEX 2'h2

// Auto-increment locations
`define IWD_AUTOINC_LO 13'h0008
`define IWD_AUTOINC_HI 13'h000F

// Machine cycle counts
`define IWD_CYC_MREF 4'h2
`define IWD_CYC_LOAD 4'h2
`define IWD_CYC_STORE 4'h2
`define IWD_CYC_ONE 4'h1
`define IWD_CYC_THREE 4'h3
`define IWD_CYC_OPR 4'h1
`define IWD_CYC_IOT_MIN 4'h2
`define IWD_CYC_EAU_SHORT 4'h1
`define IWD_CYC_EAU_LONG 4'h3
`define IWD_CYC_INDEX 4'h2
`define IWD_CYC_INDIRECT 4'h1
`define IWD_CYC_AUTOINC 4'h2

`endif

/* File: hdl/iwd_pkg.sv */
// Types shared by the instruction word decoder modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package iwd_pkg;
   typedef logic [17:0] iwd_word_t;
   typedef enum logic [2:0] {
      IWD_CLS_MEMREF,
      IWD_CLS_EAU,
      IWD_CLS_IOT,
      IWD_CLS_INDEX,
      IWD_CLS_OPERATE,
      IWD_CLS_ILLEGAL
   } iwd_class_t;
endpackage : iwd_pkg
`default_nettype wire

/* File: hdl/iwd_if.sv */
// Decoded fields passed between the decoder top and its two helpers.
// Assumes iwd_pkg is compiled first.
`default_nettype none
interface iwd_if;
   iwd_pkg::iwd_word_t word;
   logic bank_mode;
   iwd_pkg::iwd_class_t cls;
   logic [3:0] opcode;
   logic indirect;
   logic index_add;
   logic [12:0] oper_addr;
   logic [13:0] micro;
   logic autoinc;
   logic [3:0] cycles;
   logic eau_var;

   modport top (output word, bank_mode, input cls, opcode, indirect,
      index_add, oper_addr, micro, autoinc, cycles, eau_var);
   modport extract (input word, bank_mode, output cls, opcode, indirect,
      index_add, oper_addr, micro, autoinc);
   modport count (input word, cls, opcode, indirect, autoinc,
      output cycles, eau_var);
endinterface : iwd_if
`default_nettype wire

/* File: hdl/iwd_field_extract.sv */
// Combinational class and field extraction from one instruction word.
// Assumes the word and addressing mode are stable for the cycle.
`include "iwd_defs.svh"
`default_nettype none
module iwd_field_extract (
   iwd_if.extract f
);
   logic [3:0] op;
   logic [1:0] sub;

   always_comb begin
      op = f.word[`IWD_OP_HI:`IWD_OP_LO];
      sub = f.word[`IWD_SUB_HI:`IWD_SUB_LO];
      f.opcode = op;
      f.micro = f.word[`IWD_MICRO_HI:0];
      f.cls = iwd_pkg::IWD_CLS_MEMREF;
      if (op == `IWD_OP_EAU) begin
         f.cls = iwd_pkg::IWD_CLS_EAU;
      end else if (op == `IWD_OP_OPR) begin
         f.cls = iwd_pkg::IWD_CLS_OPERATE;
      end else if (op == `IWD_OP_GRP7) begin
         if (sub == `IWD_SUB_IOT) begin
            f.cls = iwd_pkg::IWD_CLS_IOT;
         end else if (sub == `IWD_SUB_INDEX) begin
            f.cls = iwd_pkg::IWD_CLS_INDEX;
         end else begin
            f.cls = iwd_pkg::IWD_CLS_ILLEGAL;
         end
      end
      // Only memory-reference words carry addressing fields
      f.indirect = 1'b0;
      f.index_add = 1'b0;
      f.oper_addr = 13'h0000;
      if (f.cls == iwd_pkg::IWD_CLS_MEMREF) begin
         f.indirect = f.word[`IWD_IND_BIT];
         if (f.bank_mode) begin
            f.oper_addr = f.word[`IWD_BANK_ADDR_HI:0];
         end else begin
            f.index_add = f.word[`IWD_IDX_BIT];
            f.oper_addr = {1'b0, f.word[`IWD_PAGE_ADDR_HI:0]};
         end
      end
      f.autoinc = f.indirect && (f.oper_addr >= `IWD_AUTOINC_LO)
         && (f.oper_addr <= `IWD_AUTOINC_HI);
   end
endmodule : iwd_field_extract
`default_nettype wire

/* File: hdl/iwd_cycle_count.sv */
// Combinational machine-cycle count for one decoded word.
// Assumes fields come from iwd_field_extract in the same cycle.
`include "iwd_defs.svh"
`default_nettype none
module iwd_cycle_count (
   iwd_if.count c
);
   logic [3:0] base;

   always_comb begin
      base = `IWD_CYC_MREF;
      c.eau_var = 1'b0;
      case (c.cls)
         iwd_pkg::IWD_CLS_OPERATE: base = `IWD_CYC_OPR;
         // Transfer length grows with the low pulse bits set
         iwd_pkg::IWD_CLS_IOT: base = `IWD_CYC_IOT_MIN
            + {3'h0, c.word[1]} + {3'h0, c.word[0]};
         iwd_pkg::IWD_CLS_INDEX: base = `IWD_CYC_INDEX;
         iwd_pkg::IWD_CLS_EAU: begin
            base = c.word[`IWD_IND_BIT] ? `IWD_CYC_EAU_LONG
               : `IWD_CYC_EAU_SHORT;
            c.eau_var = 1'b1;
         end
         iwd_pkg::IWD_CLS_MEMREF: begin
            case (c.opcode)
               `IWD_OP_LOAD: base = `IWD_CYC_LOAD;
               `IWD_OP_STORE: base = `IWD_CYC_STORE;
               `IWD_OP_EXEC, `IWD_OP_JUMP: base = `IWD_CYC_ONE;
               `IWD_OP_INCSKIP, `IWD_OP_ADD1: base = `IWD_CYC_THREE;
               default: base = `IWD_CYC_MREF;
            endcase
         end
         default: base = `IWD_CYC_ONE;
      endcase
      c.cycles = base;
      if (c.autoinc) begin
         c.cycles = base + `IWD_CYC_AUTOINC;
      end else if (c.indirect) begin
         c.cycles = base + `IWD_CYC_INDIRECT;
      end
   end
endmodule : iwd_cycle_count
`default_nettype wire

/* File: hdl/iwd_decoder.sv */
// Instruction word decoder top: registers decoded words for the sequencer
// and resolves a single level of indirection.
// Assumes fetch and sequencer logic run on clk_sys; no synchronisers needed.
//
// Summary of operation
// - Every word is either memory-reference or augmented.
// - Bits 0-3 give the opcode, selecting one of 13 memory instructions.
// - Page mode: bit 4 indirect, bit 5 index add, address bits 6-17.
// - Bank mode: bit 4 indirect, address bits 5-17, never indexed.
// - Bits 0-3 equal to octal 64 mean extended arithmetic.
// - Bits 0-5 octal 70 is io transfer, octal 72 is index.
// - Bits 0-3 equal to octal 74 mean operate.
// - Combined micro-functions of one group all run in its time.
// - Operate 1, io 2-4, arithmetic 1 or 3 plus variable, index 2.
// - Indirect addressing costs one extra machine cycle.
// - Only one indirection level; fetched word is the final address.
// - Indirect through an auto-increment location costs two extra cycles.
// - Load, octal 20, two cycles, memory word into working register.
// - Store is decoded from octal 04 and takes two cycles.
// - Store writes working register to memory, register left unchanged.
`include "iwd_defs.svh"
`default_nettype none
module iwd_decoder (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Fetch side
   input wire logic instr_valid,
   input wire logic [17:0] instr_word,
   input wire logic bank_mode,
   output logic dec_busy,
   // Indirect word return from memory
   input wire logic ind_valid,
   input wire logic [17:0] ind_word,
   // Decoded word to the sequencer
   output logic dec_valid,
   output iwd_pkg::iwd_class_t dec_class,
   output logic [3:0] dec_opcode,
   output logic dec_indirect,
   output logic dec_index_add,
   output logic dec_autoinc,
   output logic [12:0] dec_oper_addr,
   output logic [13:0] dec_micro,
   output logic [3:0] dec_cycles,
   output logic dec_eau_var,
   output logic dec_illegal,
   // Data movement for the memory-reference instruction
   output logic dec_mem_read,
   output logic dec_mem_write,
   output logic dec_write_zero,
   output logic dec_wreg_load,
   output logic dec_wreg_to_mem,
   // Effective address
   output logic ea_valid,
   output logic [12:0] ea_addr
);
   typedef enum logic {
      IWD_S_IDLE,
      IWD_S_WAIT_IND
   } iwd_state_t;

   iwd_if f();

   iwd_field_extract u_extract (
      .f(f)
   );

   iwd_cycle_count u_count (
      .c(f)
   );

   assign f.word = instr_word;
   assign f.bank_mode = bank_mode;

   iwd_state_t state;
   iwd_state_t next_state;

   // Decoded word registers
   logic next_dec_valid;
   iwd_pkg::iwd_class_t next_dec_class;
   logic [3:0] next_dec_opcode;
   logic next_dec_indirect;
   logic next_dec_index_add;
   logic next_dec_autoinc;
   logic [12:0] next_dec_oper_addr;
   logic [13:0] next_dec_micro;
   logic [3:0] next_dec_cycles;
   logic next_dec_eau_var;
   logic next_dec_illegal;
   logic next_dec_mem_read;
   logic next_dec_mem_write;
   logic next_dec_write_zero;
   logic next_dec_wreg_load;
   logic next_dec_wreg_to_mem;
   logic next_dec_busy;
   logic next_ea_valid;
   logic [12:0] next_ea_addr;

   // Memory-movement decode of the current word
   logic is_mref;
   logic rd;
   logic wr;
   logic wz;
   logic wl;
   logic ws;
   logic take;

   always_comb begin
      is_mref = (f.cls == iwd_pkg::IWD_CLS_MEMREF);
      rd = 1'b0;
      wr = 1'b0;
      wz = 1'b0;
      wl = 1'b0;
      ws = 1'b0;
      if (is_mref) begin
         case (f.opcode)
            `IWD_OP_LOAD: begin
               rd = 1'b1;
               wl = 1'b1;
            end
            `IWD_OP_STORE: begin
               wr = 1'b1;
               ws = 1'b1;
            end
            `IWD_OP_ZERO: begin
               wr = 1'b1;
               wz = 1'b1;
            end
            `IWD_OP_XOR, `IWD_OP_ADD1, `IWD_OP_ADD2, `IWD_OP_AND: begin
               rd = 1'b1;
               wl = 1'b1;
            end
            `IWD_OP_INCSKIP: begin
               rd = 1'b1;
               wr = 1'b1;
            end
            `IWD_OP_SKIPNE, `IWD_OP_EXEC: begin
               rd = 1'b1;
            end
            `IWD_OP_CALL, `IWD_OP_JSUB: begin
               wr = 1'b1;
            end
            `IWD_OP_JUMP: begin
               rd = 1'b0;
            end
            default: begin
               rd = 1'b0;
            end
         endcase
      end
   end

   // A word is only taken while no indirect fetch is outstanding
   assign take = instr_valid && (state == IWD_S_IDLE);

   // Handshake group: wait state, strobes and effective address
   always_comb begin
      next_state = state;
      next_dec_busy = dec_busy;
      next_dec_valid = 1'b0;
      next_ea_valid = 1'b0;
      next_ea_addr = ea_addr;
      case (state)
         IWD_S_IDLE: begin
            if (take) begin
               next_dec_valid = 1'b1;
               if (is_mref && f.indirect) begin
                  next_state = IWD_S_WAIT_IND;
                  next_dec_busy = 1'b1;
               end else if (is_mref) begin
                  next_ea_valid = 1'b1;
                  next_ea_addr = f.oper_addr;
               end
            end
         end
         IWD_S_WAIT_IND: begin
            // Busy drops with the address strobe; fetch may offer next edge
            if (ind_valid) begin
               // Fetched word is final; its own bit 4 is never honoured
               next_ea_valid = 1'b1;
               next_ea_addr = ind_word[`IWD_BANK_ADDR_HI:0];
               next_dec_busy = 1'b0;
               next_state = IWD_S_IDLE;
            end
         end
         default: begin
            // Unused encoding: fall back to idle and free the fetch side
            next_state = IWD_S_IDLE;
            next_dec_busy = 1'b0;
         end
      endcase
   end

   // Field group: loaded from a taken word, held until the next one
   always_comb begin
      next_dec_class = dec_class;
      next_dec_opcode = dec_opcode;
      next_dec_indirect = dec_indirect;
      next_dec_index_add = dec_index_add;
      next_dec_autoinc = dec_autoinc;
      next_dec_oper_addr = dec_oper_addr;
      next_dec_micro = dec_micro;
      next_dec_cycles = dec_cycles;
      next_dec_eau_var = dec_eau_var;
      next_dec_illegal = dec_illegal;
      if (take) begin
         next_dec_class = f.cls;
         next_dec_opcode = f.opcode;
         next_dec_indirect = f.indirect;
         next_dec_index_add = f.index_add;
         next_dec_autoinc = f.autoinc;
         next_dec_oper_addr = f.oper_addr;
         // Whole code field passes at once so combined codes
         // all execute inside the group's single time slot
         next_dec_micro = is_mref ? 14'h0000 : f.micro;
         next_dec_cycles = f.cycles;
         next_dec_eau_var = f.eau_var;
         // Illegal words still pulse dec_valid so the sequencer can trap
         next_dec_illegal = (f.cls == iwd_pkg::IWD_CLS_ILLEGAL);
      end
   end

   // Movement group: levels, so the sequencer qualifies them by dec_valid
   always_comb begin
      next_dec_mem_read = dec_mem_read;
      next_dec_mem_write = dec_mem_write;
      next_dec_write_zero = dec_write_zero;
      next_dec_wreg_load = dec_wreg_load;
      next_dec_wreg_to_mem = dec_wreg_to_mem;
      if (take) begin
         next_dec_mem_read = rd;
         next_dec_mem_write = wr;
         next_dec_write_zero = wz;
         next_dec_wreg_load = wl;
         next_dec_wreg_to_mem = ws;
      end
   end

   // Handshake registers; reset drops any indirect fetch in flight
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= IWD_S_IDLE;
         dec_busy <= 1'b0;
         dec_valid <= 1'b0;
         ea_valid <= 1'b0;
         ea_addr <= 13'h0000;
      end else begin
         state <= next_state;
         dec_busy <= next_dec_busy;
         dec_valid <= next_dec_valid;
         ea_valid <= next_ea_valid;
         ea_addr <= next_ea_addr;
      end
   end

   // Field registers; only a taken word changes them
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dec_class <= iwd_pkg::IWD_CLS_MEMREF;
         dec_opcode <= 4'h0;
         dec_indirect <= 1'b0;
         dec_index_add <= 1'b0;
         dec_autoinc <= 1'b0;
         dec_oper_addr <= 13'h0000;
         dec_micro <= 14'h0000;
         dec_cycles <= 4'h0;
         dec_eau_var <= 1'b0;
         dec_illegal <= 1'b0;
      end else begin
         dec_class <= next_dec_class;
         dec_opcode <= next_dec_opcode;
         dec_indirect <= next_dec_indirect;
         dec_index_add <= next_dec_index_add;
         dec_autoinc <= next_dec_autoinc;
         dec_oper_addr <= next_dec_oper_addr;
         dec_micro <= next_dec_micro;
         dec_cycles <= next_dec_cycles;
         dec_eau_var <= next_dec_eau_var;
         dec_illegal <= next_dec_illegal;
      end
   end

   // Movement strobe registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dec_mem_read <= 1'b0;
         dec_mem_write <= 1'b0;
         dec_write_zero <= 1'b0;
         dec_wreg_load <= 1'b0;
         dec_wreg_to_mem <= 1'b0;
      end else begin
         dec_mem_read <= next_dec_mem_read;
         dec_mem_write <= next_dec_mem_write;
         dec_write_zero <= next_dec_write_zero;
         dec_wreg_load <= next_dec_wreg_load;
         dec_wreg_to_mem <= next_dec_wreg_to_mem;
      end
   end
endmodule : iwd_decoder
`default_nettype wire

/* File: verif/iwd_decoder_assertions.sv */
// Port-level checker for the instruction word decoder.
// Assumes one clock domain and a bind from the bench top file.
`default_nettype none
module iwd_decoder_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Fetch and indirect return
   input wire logic instr_valid,
   input wire logic [17:0] instr_word,
   input wire logic bank_mode,
   input wire logic ind_valid,
   input wire logic [17:0] ind_word,
   // Decoded outputs
   input wire logic dec_busy,
   input wire logic dec_valid,
   input wire iwd_pkg::iwd_class_t dec_class,
   input wire logic dec_indirect,
   input wire logic dec_index_add,
   input wire logic [12:0] dec_oper_addr,
   input wire logic [13:0] dec_micro,
   input wire logic [3:0] dec_cycles,
   input wire logic dec_eau_var,
   input wire logic dec_mem_read,
   input wire logic dec_mem_write,
   input wire logic dec_wreg_load,
   input wire logic dec_wreg_to_mem,
   input wire logic ea_valid,
   input wire logic [12:0] ea_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   logic [17:0] w_q;
   logic [17:0] iw_q;
   logic [12:0] oa_q;
   assign take = instr_valid && !dec_busy;
   // Sampled copies so consequents see the word of the taking edge
   always_ff @(posedge clk_sys) begin
      w_q <= instr_word;
      iw_q <= ind_word;
      oa_q <= bank_mode ? instr_word[12:0] : {1'h0, instr_word[11:0]};
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_take(logic [3:0] op);
      take && instr_word[17:14] == op;
   endsequence
   sequence s_ret;
      ea_valid && !dec_busy && ea_addr == iw_q[12:0];
   endsequence
   property p_accept; take |=> dec_valid; endproperty
   property p_load; s_take(4'h4) ##0 !instr_word[13] |=> dec_cycles == 4'h2
      && dec_mem_read && dec_wreg_load && !dec_mem_write; endproperty
   property p_store; s_take(4'h1) ##0 !instr_word[13] |=> dec_cycles == 4'h2
      && dec_mem_write && dec_wreg_to_mem && !dec_wreg_load; endproperty
   property p_page; take && !bank_mode && instr_word[17:14] < 4'hD |=>
      dec_oper_addr == {1'h0, w_q[11:0]} && dec_index_add == w_q[12]
      && dec_indirect == w_q[13]; endproperty
   property p_bank; take && bank_mode && instr_word[17:14] < 4'hD |=>
      dec_oper_addr == w_q[12:0] && !dec_index_add; endproperty
   property p_eau; s_take(4'hD) |=> dec_class == iwd_pkg::IWD_CLS_EAU &&
      dec_eau_var && dec_cycles == (w_q[13] ? 4'h3 : 4'h1); endproperty
   property p_iot; take && instr_word[17:12] == 6'h38 |=> dec_class ==
      iwd_pkg::IWD_CLS_IOT && dec_cycles == 4'h2 + w_q[1] + w_q[0]; endproperty
   property p_index; take && instr_word[17:12] == 6'h3A |=>
      dec_class == iwd_pkg::IWD_CLS_INDEX && dec_cycles == 4'h2; endproperty
   property p_opr; s_take(4'hF) |=> dec_class == iwd_pkg::IWD_CLS_OPERATE &&
      dec_cycles == 4'h1 && dec_micro == w_q[13:0] && !ea_valid; endproperty
   property p_direct; take && instr_word[17:14] < 4'hD && !instr_word[13]
      |=> ea_valid && ea_addr == oa_q && !dec_busy; endproperty
   property p_ind_cyc; s_take(4'h4) ##0 instr_word[13] |=> dec_busy &&
      dec_cycles == ((oa_q >= 13'h0008 && oa_q <= 13'h000F) ? 4'h4 : 4'h3);
   endproperty
   property p_wait; dec_busy && !ind_valid |=> dec_busy && !dec_valid
      && !ea_valid; endproperty
   property p_ind_ret; dec_busy && ind_valid && !instr_valid |=> s_ret;
   endproperty
   a_accept: assert property (p_accept) else $error("word not taken");
   a_load: assert property (p_load) else $error("load decode wrong");
   a_store: assert property (p_store) else $error("store wrong");
   a_page: assert property (p_page) else $error("page fields wrong");
   a_bank: assert property (p_bank) else $error("bank fields wrong");
   a_eau: assert property (p_eau) else $error("arith decode wrong");
   a_iot: assert property (p_iot) else $error("io decode wrong");
   a_index: assert property (p_index) else $error("index wrong");
   a_opr: assert property (p_opr) else $error("operate wrong");
   a_direct: assert property (p_direct) else $error("direct ea wrong");
   a_ind_cyc: assert property (p_ind_cyc) else $error("penalty wrong");
   a_wait: assert property (p_wait) else $error("busy broken");
   a_ind_ret: assert property (p_ind_ret) else $error("second level");
endmodule : iwd_decoder_assertions
`default_nettype wire

/* File: verif/iwd_mem_model.sv */
// Memory side model returning the word behind an indirect pointer.
// Assumes the bench sets the pointer contents and the answer delay.
`default_nettype none
module iwd_mem_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Control
   input wire logic dec_busy,
   input wire logic [3:0] delay,
   input wire logic [17:0] ptr_word,
   // Indirect return
   output logic ind_valid,
   output logic [17:0] ind_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_cnt;
   // Data line toggles when idle so stale words never look valid
   always @(negedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wait_cnt <= 4'h0;
         ind_valid <= 1'h0;
         ind_word <= 18'h00000;
      end else begin
         ind_valid <= dec_busy && wait_cnt == delay;
         ind_word <= (dec_busy && wait_cnt == delay) ? ptr_word : ~ind_word;
         wait_cnt <= dec_busy ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule : iwd_mem_model
`default_nettype wire

/* File: verif/iwd_decoder_tb_top.sv */
// Bench top: table of single words, then reset and indirect cases.
// Assumes design, checker and memory model are compiled first.
`default_nettype none
module iwd_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic bank;
      logic [17:0] word;
      iwd_pkg::iwd_class_t cls;
      logic [3:0] cyc;
      logic [12:0] addr;
      logic idx;
      logic [4:0] flg;
   } iwd_row_t;
   localparam iwd_pkg::iwd_class_t CM = iwd_pkg::IWD_CLS_MEMREF;
   localparam iwd_pkg::iwd_class_t CL = iwd_pkg::IWD_CLS_ILLEGAL;
   localparam iwd_pkg::iwd_class_t CE = iwd_pkg::IWD_CLS_EAU;
   logic clk_sys = 1'h0;
   logic rstn, instr_valid, bank_mode, ind_valid, dec_busy, dec_valid;
   logic dec_indirect, dec_index_add, dec_autoinc, dec_eau_var, dec_illegal;
   logic dec_mem_read, dec_mem_write, dec_write_zero, dec_wreg_load;
   logic dec_wreg_to_mem, ea_valid;
   logic [17:0] instr_word, ind_word, ptr_word;
   logic [12:0] dec_oper_addr, ea_addr;
   logic [13:0] dec_micro;
   logic [3:0] dec_cycles, delay, dec_opcode;
   iwd_pkg::iwd_class_t dec_class;
   iwd_row_t rows [23];
   iwd_row_t r;
   int error_cnt = 0;
   int num_checks = 0;
   always #20 clk_sys = ~clk_sys;
   iwd_decoder iwd_decoder_i (.clk_sys, .rstn, .instr_valid, .instr_word,
      .bank_mode, .dec_busy, .ind_valid, .ind_word, .dec_valid, .dec_class,
      .dec_opcode, .dec_indirect, .dec_index_add, .dec_autoinc,
      .dec_oper_addr, .dec_micro, .dec_cycles, .dec_eau_var, .dec_illegal,
      .dec_mem_read, .dec_mem_write, .dec_write_zero, .dec_wreg_load,
      .dec_wreg_to_mem, .ea_valid, .ea_addr);
   iwd_mem_model iwd_mem_model_i (.clk_sys, .rstn, .dec_busy, .delay,
      .ptr_word, .ind_valid, .ind_word);
   function automatic iwd_row_t mr(input logic [3:0] op,
         input logic [3:0] cyc, input logic [4:0] flg);
      mr = '{1'h0, {op, 2'h1, 12'h123}, CM, cyc, 13'h0123, 1'h1, flg};
   endfunction : mr
   function automatic iwd_row_t ag(input logic [17:0] w,
         input iwd_pkg::iwd_class_t c, input logic [3:0] cyc);
      ag = '{1'h0, w, c, cyc, 13'h0000, 1'h0, 5'h00};
   endfunction : ag
   task automatic chk(input string nm, input logic [17:0] e,
         input logic [17:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_cls(input iwd_pkg::iwd_class_t e,
         input iwd_pkg::iwd_class_t g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD class exp %0d got %0d", e, g);
      end
   endtask : chk_cls
   task automatic stop_test();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   // Fetched pointer word has its own indirect bit set on purpose
   task automatic ind_test(input logic bank, input logic [17:0] w,
         input logic [3:0] cyc, input logic [3:0] dly);
      delay = dly;
      ptr_word = {5'h1F, w[12:0] ^ 13'h1FFF};
      bank_mode = bank;
      instr_word = w;
      instr_valid = 1'h1;
      @(negedge clk_sys);
      chk("indirect", {2'h3, cyc}, {dec_busy, dec_indirect, dec_cycles});
      instr_word = 18'h3C000;
      repeat (dly) begin
         @(negedge clk_sys);
         chk("refused", 2'h2, {dec_busy, dec_valid});
      end
      instr_valid = 1'h0;
      @(negedge clk_sys);
      chk("return", {2'h2, ptr_word[12:0]}, {ea_valid, dec_busy, ea_addr});
   endtask : ind_test
   initial begin
      #(40 * 2000);
      error_cnt++;
      stop_test();
   end
   initial begin
      rstn = 1'h0;
      instr_valid = 1'h0;
      instr_word = 18'h00000;
      bank_mode = 1'h0;
      delay = 4'h0;
      ptr_word = 18'h00000;
      rows = '{mr(4'h0, 4'h2, 5'h08), mr(4'h1, 4'h2, 5'h09),
         mr(4'h2, 4'h2, 5'h08), mr(4'h3, 4'h2, 5'h0C), mr(4'h4, 4'h2, 5'h12),
         mr(4'h5, 4'h2, 5'h12), mr(4'h6, 4'h3, 5'h12), mr(4'h7, 4'h2, 5'h12),
         mr(4'h8, 4'h1, 5'h10), mr(4'h9, 4'h3, 5'h18), mr(4'hA, 4'h2, 5'h12),
         mr(4'hB, 4'h2, 5'h10), mr(4'hC, 4'h1, 5'h00),
         '{1'h1, {4'h1, 1'h0, 13'h1ABC}, CM, 4'h2, 13'h1ABC, 1'h0, 5'h09},
         ag(18'h34055, iwd_pkg::IWD_CLS_EAU, 4'h1),
         ag(18'h36001, iwd_pkg::IWD_CLS_EAU, 4'h3),
         ag(18'h38000, iwd_pkg::IWD_CLS_IOT, 4'h2),
         ag(18'h38002, iwd_pkg::IWD_CLS_IOT, 4'h3),
         ag(18'h38013, iwd_pkg::IWD_CLS_IOT, 4'h4),
         ag(18'h3A0F0, iwd_pkg::IWD_CLS_INDEX, 4'h2),
         ag(18'h3FFFF, iwd_pkg::IWD_CLS_OPERATE, 4'h1),
         ag(18'h39000, CL, 4'h1), ag(18'h3B000, CL, 4'h1)};
      repeat (10) @(negedge clk_sys);
      chk_cls(CM, dec_class);
      chk("reset", 3'h0, {dec_valid, ea_valid, dec_busy});
      rstn = 1'h1;
      for (int i = 0; i < 23; i++) begin
         instr_valid = 1'h1;
         bank_mode = rows[i].bank;
         instr_word = rows[i].word;
         @(negedge clk_sys);
         r = rows[i];
         chk_cls(r.cls, dec_class);
         chk("opcode", r.word[17:14], dec_opcode);
         chk("cycles", {r.cls == CE, r.cyc},
            {dec_eau_var, dec_cycles});
         chk("addr", {r.idx, r.addr}, {dec_index_add, dec_oper_addr});
         chk("moves", r.flg, {dec_mem_read, dec_mem_write, dec_write_zero,
            dec_wreg_load, dec_wreg_to_mem});
         chk("strobe", {1'h1, r.cls == CM}, {dec_valid, ea_valid});
         chk("micro", r.cls == CM ? 14'h0 : r.word[13:0], dec_micro);
         chk("illegal", r.cls == CL, dec_illegal);
         if (r.cls == CM) chk("ea", r.addr, ea_addr);
      end
      ind_test(1'h0, {4'h4, 2'h2, 12'h00A}, 4'h4, 4'h3);
      chk("autoinc", 1'h1, dec_autoinc);
      ind_test(1'h1, {4'h1, 1'h1, 13'h1020}, 4'h3, 4'h0);
      // Reset while an indirect fetch waits must free the decoder
      delay = 4'hF;
      bank_mode = 1'h0;
      instr_word = {4'h4, 2'h2, 12'h100};
      instr_valid = 1'h1;
      @(negedge clk_sys);
      instr_valid = 1'h0;
      rstn = 1'h0;
      @(negedge clk_sys);
      chk("midrst", 3'h0, {dec_valid, ea_valid, dec_busy});
      chk_cls(CM, dec_class);
      rstn = 1'h1;
      instr_word = {4'hC, 2'h0, 12'h456};
      instr_valid = 1'h1;
      @(negedge clk_sys);
      chk("after", {2'h2, 13'h0456}, {ea_valid, dec_busy, ea_addr});
      instr_valid = 1'h0;
      @(negedge clk_sys);
      stop_test();
   end
endmodule : iwd_decoder_tb_top
bind iwd_decoder iwd_decoder_assertions iwd_decoder_assertions_i (.clk_sys,
   .rstn, .instr_valid, .instr_word, .bank_mode, .ind_valid, .ind_word,
   .dec_busy, .dec_valid, .dec_class, .dec_indirect, .dec_index_add,
   .dec_oper_addr, .dec_micro, .dec_cycles, .dec_eau_var, .dec_mem_read,
   .dec_mem_write, .dec_wreg_load, .dec_wreg_to_mem, .ea_valid, .ea_addr);
`default_nettype wire
